// [core/ain_cfg_defs.svh]
// Constants for the analog input range and units formatter.
// Assumes inclusion by bare name from core design files and from the verification checker.
`ifndef AIN_CFG_DEFS_SVH
`define AIN_CFG_DEFS_SVH
// Range codes, wide mode
`define RANGE_BCD_10V 3'h0
`define RANGE_BCD_5V 3'h1
`define RANGE_CUR_BTD 3'h6
// Units codes
`define UNITS_SMAG13 2'h0
`define UNITS_TC13 2'h1
`define UNITS_TC12 2'h2
`define UNITS_UMAG12 2'h3
// Full scale of bipolar BCD ranges
`define BCD_FULL_10V 14'd9999
`define BCD_FULL_5V 14'd5000
// Converter full scale
`define ADC_FULL 12'hfff
// Broken loop threshold in counts (1.25 mA on a 20 mA scale)
`define BTD_LIMIT_CNT 12'd256
// Invalid-config indicator toggle interval (half the flash period) in ns
`define FLASH_NS 100000000
`define CLK_NS 40
`define FLASH_CYC (`FLASH_NS / `CLK_NS)
// Result word layout
`define CHAN_ONEHOT_LSB 16
`define BTD_BIT 14
`define SIGN_BIT 15
// Wide mode per-channel sign and broken-loop flags in the upper word
`define SIGN_HI_LSB 20
`define BTD_HI_LSB 24
`endif

// [core/ain_cfg_pkg.sv]
// Types for the analog input range and units formatter.
// Assumes no surroundings.
package ain_cfg_pkg;
    typedef enum logic [1:0] {ST_STRAP, ST_RUN, ST_BAD} ain_state_t;
endpackage

// [core/word_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    // Storage array
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic push, pop;

    // Honest flags straight from the occupancy count
    assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem[rd_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer and count updates
    always_comb
    begin
        nxt_wr = push ? ((wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1) : wr_ff;
        nxt_rd = pop ? ((rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1) : rd_ff;
        nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Registering of pointers
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end

    // Data array has no reset; only valid slots are read
    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem[wr_ff] <= in_data;
    end
endmodule
`default_nettype wire

// [core/ain_range_fmt.sv]
// Range/units decoder and result formatter of a four-channel analog input.
// Assumes conversions arrive as 12-bit offset codes on the same clock, and
// that straps and scan strobe are pins needing synchronisation.
`timescale 1ns/1ps
`default_nettype none
`include "ain_cfg_defs.svh"
module ain_range_fmt
    import ain_cfg_pkg::*;
#(
    parameter int FLASH_CYC = `FLASH_CYC,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic wide_mode_pin,
    input wire logic [2:0] range_pin,
    input wire logic [1:0] units_pin,
    input wire logic [1:0] chan_cnt_pin,
    input wire logic [3:0] valid_cfg_pin,
    input wire logic scan_pin,
    input wire logic [47:0] adc_codes,
    output logic [31:0] result_word,
    output logic result_valid,
    output logic run_led,
    output logic ch1_led,
    output logic cfg_bad
);
    // Two-stage synchronisers for all pins
    logic [10:0] sync1_ff, sync2_ff;
    logic [3:0] diag1_ff, diag2_ff;
    logic scan1_ff, scan2_ff, scan3_ff;
    // Held straps
    logic wide_ff, nxt_wide;
    logic [2:0] range_ff, nxt_range;
    logic [1:0] units_ff, nxt_units;
    logic [1:0] last_ff, nxt_last;
    ain_state_t state_ff, nxt_state;
    // Channel rotation and indicator timing
    logic [1:0] chan_ff, nxt_chan;
    logic [31:0] flash_ff, nxt_flash;
    logic blink_ff, nxt_blink;
    logic [31:0] out_ff, nxt_out;
    logic ov_ff, nxt_ov;
    logic [1:0] wait_ff, nxt_wait; // Settling count before straps are taken
    // Indicator registers so lamps come straight from flops
    logic run_led_ff, nxt_run_led, ch1_led_ff, nxt_ch1_led, bad_ff, nxt_bad;
    // FIFO link
    logic scan_evt, fifo_in_ready, fifo_out_valid;
    logic [31:0] word_in, fifo_out;
    logic [17:0] fw; // Formatted data, bit 16 sign, bit 17 broken loop

    // Binary to four-digit BCD by double dabble
    function automatic logic [15:0] to_bcd(input logic [13:0] v);
        logic [29:0] s;
        s = {16'h0000, v};
        for (int i = 0; i < 14; i++)
        begin
            for (int d = 0; d < 4; d++)
                if (s[14+4*d +: 4] > 4'h4)
                    s[14+4*d +: 4] = s[14+4*d +: 4] + 4'h3;
            s = s << 1;
        end
        return s[29:14];
    endfunction

    // Scale a 12-bit magnitude to a decimal full scale
    function automatic logic [13:0] scale(input logic [11:0] m, input logic [13:0] fs);
        logic [25:0] p;
        p = 26'(m) * 26'(fs);
        return 14'(p / 26'(`ADC_FULL));
    endfunction

    // Format one channel's code into the data word
    function automatic logic [17:0] fmt(input logic [11:0] code, input logic wide,
                                        input logic [2:0] rng, input logic [1:0] un);
        logic bip, neg, btd;
        logic [11:0] mag;
        logic [12:0] tc;
        logic [12:0] dif, dbl;
        fmt = '0;
        bip = (rng == 3'h2) || (rng == 3'h3) || (rng == `RANGE_BCD_10V)
              || (rng == `RANGE_BCD_5V);
        neg = bip && !code[11];
        // Bipolar codes are offset binary; full negative would wrap, so clamp it
        dif = neg ? 13'(13'h0800 - {1'b0, code}) : 13'({1'b0, code} - 13'h0800);
        dbl = {dif[11:0], 1'b0};
        mag = !bip ? code : (dbl[12] ? 12'hfff : dbl[11:0]);
        btd = (rng == `RANGE_CUR_BTD) && (code <= `BTD_LIMIT_CNT);
        tc = neg ? 13'(-{1'b0, mag}) : {1'b0, mag};
        if (!wide)
            fmt[15:0] = {neg, btd, 2'b00, mag};
        else if (rng == `RANGE_BCD_10V)
            fmt[15:0] = to_bcd(scale(mag, `BCD_FULL_10V));
        else if (rng == `RANGE_BCD_5V)
            fmt[15:0] = to_bcd(scale(mag, `BCD_FULL_5V));
        else
        begin
            unique case (un)
                `UNITS_SMAG13: fmt[15:0] = {3'b000, neg, mag};
                `UNITS_TC13: fmt[15:0] = {{3{tc[12]}}, tc};
                `UNITS_TC12: fmt[15:0] = {4'h0, tc[12:1]};
                `UNITS_UMAG12: fmt[15:0] = {4'h0, neg ? 12'h000 : mag};
            endcase
        end
        // Four BCD digits fill the data half, so flags travel beside it
        fmt[17:16] = {btd, neg};
    endfunction

    // Synchronise pins before any logic reads them
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            diag1_ff <= '0;
            diag2_ff <= '0;
            scan1_ff <= 1'b0;
            scan2_ff <= 1'b0;
            scan3_ff <= 1'b0;
        end
        else
        begin
            sync1_ff <= {wide_mode_pin, range_pin, units_pin, chan_cnt_pin, 3'b000};
            sync2_ff <= sync1_ff;
            diag1_ff <= valid_cfg_pin;
            diag2_ff <= diag1_ff;
            scan1_ff <= scan_pin;
            scan2_ff <= scan1_ff;
            scan3_ff <= scan2_ff;
        end
    end

    // Rising edge of the host scan strobe
    assign scan_evt = scan2_ff && !scan3_ff;

    // Strap capture, rotation, indicators
    always_comb
    begin
        nxt_state = state_ff;
        nxt_wide = wide_ff;
        nxt_range = range_ff;
        nxt_units = units_ff;
        nxt_last = last_ff;
        nxt_chan = chan_ff;
        nxt_flash = flash_ff;
        nxt_blink = blink_ff;
        nxt_out = fifo_out_valid ? fifo_out : out_ff;
        nxt_ov = 1'b0;
        nxt_wait = wait_ff;
        unique case (state_ff)
            ST_STRAP:
            begin
                // Synchronisers hold reset zeros until two edges have passed
                nxt_wait = wait_ff + 2'd1;
                if (wait_ff == 2'd2)
                begin
                    // Capture once; straps then held for the whole run
                    nxt_wide = sync2_ff[10];
                    nxt_range = sync2_ff[9:7];
                    nxt_units = sync2_ff[6:5];
                    nxt_last = sync2_ff[4:3];
                    // Diagnostic input marks bad straps seen by the front end
                    nxt_state = (diag2_ff != 4'h0) ? ST_BAD : ST_RUN;
                end
            end
            ST_RUN:
            begin
                // Slow heartbeat while healthy
                nxt_flash = (flash_ff >= 32'(FLASH_CYC * 5 - 1)) ? '0 : flash_ff + 1;
                if (flash_ff == '0)
                    nxt_blink = !blink_ff;
                if (scan_evt && fifo_in_ready)
                begin
                    nxt_ov = 1'b1;
                    nxt_chan = (chan_ff == last_ff) ? 2'd0 : chan_ff + 2'd1;
                end
            end
            ST_BAD:
            begin
                // Fast flash of channel one
                nxt_flash = (flash_ff >= 32'(FLASH_CYC - 1)) ? '0 : flash_ff + 1;
                if (flash_ff == '0)
                    nxt_blink = !blink_ff;
            end
        endcase
        // Lamps follow the next state so they move together with it
        nxt_bad = (nxt_state == ST_BAD);
        nxt_run_led = (nxt_state == ST_RUN) && nxt_blink;
        nxt_ch1_led = (nxt_state == ST_BAD) ? nxt_blink
                      : ((nxt_state == ST_RUN) && (nxt_chan == 2'd0));
    end

    // Word for current channel; upper half holds channel one-hot and per-channel flags in wide mode
    always_comb
    begin
        fw = fmt(adc_codes[12*chan_ff +: 12], wide_ff, range_ff, units_ff);
        word_in = '0;
        word_in[15:0] = fw[15:0];
        if (wide_ff)
        begin
            word_in[`CHAN_ONEHOT_LSB +: 4] = 4'h1 << chan_ff;
            word_in[`SIGN_HI_LSB + chan_ff] = fw[16];
            word_in[`BTD_HI_LSB + chan_ff] = fw[17];
        end
        else
            word_in[13:12] = chan_ff;
    end

    // State, strap and output registers
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wait_ff <= 2'h0;
            run_led_ff <= 1'b0;
            ch1_led_ff <= 1'b0;
            bad_ff <= 1'b0;
            state_ff <= ST_STRAP;
            wide_ff <= 1'b0;
            range_ff <= 3'h0;
            units_ff <= 2'h0;
            last_ff <= 2'h0;
            chan_ff <= 2'h0;
            flash_ff <= '0;
            blink_ff <= 1'b0;
            out_ff <= '0;
            ov_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            wide_ff <= nxt_wide;
            range_ff <= nxt_range;
            units_ff <= nxt_units;
            last_ff <= nxt_last;
            chan_ff <= nxt_chan;
            flash_ff <= nxt_flash;
            blink_ff <= nxt_blink;
            out_ff <= nxt_out;
            ov_ff <= fifo_out_valid;
            wait_ff <= nxt_wait;
            run_led_ff <= nxt_run_led;
            ch1_led_ff <= nxt_ch1_led;
            bad_ff <= nxt_bad;
        end
    end

    // Buffer between formatter and host port; host drains one per cycle
    word_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .in_valid(nxt_ov),
        .in_ready(fifo_in_ready),
        .in_data(word_in),
        .out_valid(fifo_out_valid),
        .out_ready(1'b1),
        .out_data(fifo_out)
    );

    // Registered outputs
    assign result_word = out_ff;
    assign result_valid = ov_ff;
    assign run_led = run_led_ff;
    assign ch1_led = ch1_led_ff;
    assign cfg_bad = bad_ff;
endmodule
`default_nettype wire

// [verification/ain_range_fmt_asserts.sv]
// Port checker for the range and units formatter.
// Assumes straps only move while reset is held.
`timescale 1ns/1ps
`default_nettype none
`include "ain_cfg_defs.svh"
module ain_range_fmt_asserts #(
    parameter int FLASH_CYC = 4
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic wide_mode_pin,
    input wire logic [2:0] range_pin,
    input wire logic scan_pin,
    input wire logic [31:0] result_word,
    input wire logic result_valid,
    input wire logic run_led,
    input wire logic ch1_led,
    input wire logic cfg_bad
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    logic ch1_q_ff; // Lamp level one cycle ago
    int same_ff; // Cycles since the lamp last moved
    int nxt_same; // Next value of that count
    // A lamp that never moves would read as a steady fault, not a flash
    always_comb
    begin
        nxt_same = (ch1_led != ch1_q_ff) ? 0 : same_ff + 1;
    end
    // Register the lamp history
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ch1_q_ff <= 1'b0;
            same_ff <= 0;
        end
        else
        begin
            ch1_q_ff <= ch1_led;
            same_ff <= nxt_same;
        end
    end
    // Host strobe taken while running
    sequence scan_rise;
        $rose(scan_pin) && !cfg_bad;
    endsequence
    // Formatted word coming back
    sequence answer;
        ##[2:8] result_valid;
    endsequence
    a_scan_gets_answer: assert property (scan_rise |-> answer)
        else $error("scan not answered");
    a_valid_single_pulse: assert property (result_valid |=> !result_valid)
        else $error("result valid too long");
    a_word_holds: assert property (!result_valid |-> $stable(result_word))
        else $error("result word moved without valid");
    a_bad_run_dark: assert property (cfg_bad |-> !run_led)
        else $error("run lamp lit on bad config");
    a_bad_no_result: assert property (cfg_bad |-> !result_valid)
        else $error("result given on bad config");
    a_bad_lamp_flash: assert property (cfg_bad |-> same_ff <= 2 * FLASH_CYC + 4)
        else $error("channel one lamp not flashing");
    a_wide_chan_onehot: assert property (result_valid && wide_mode_pin |-> $onehot(result_word[19:16]))
        else $error("channel field not one-hot");
    a_broken_only_loop: assert property (result_valid && (wide_mode_pin ?
        (result_word[`BTD_HI_LSB +: 4] != 4'h0) : result_word[`BTD_BIT])
        |-> range_pin == `RANGE_CUR_BTD)
        else $error("broken flag outside loop range");
    a_unipolar_sign_off: assert property (result_valid && range_pin == 3'h4 |->
        !result_word[`SIGN_BIT] && result_word[`SIGN_HI_LSB +: 4] == 4'h0)
        else $error("sign set on unipolar range");
    a_narrow_upper_zero: assert property (result_valid && !wide_mode_pin |->
        result_word[31:16] == 16'h0000)
        else $error("upper word used in narrow mode");
endmodule
bind ain_range_fmt ain_range_fmt_asserts #(.FLASH_CYC(FLASH_CYC)) u_asserts (
    .clk_sys(clk_sys), .arst_n(arst_n), .wide_mode_pin(wide_mode_pin), .range_pin(range_pin),
    .scan_pin(scan_pin), .result_word(result_word), .result_valid(result_valid),
    .run_led(run_led), .ch1_led(ch1_led), .cfg_bad(cfg_bad));
`default_nettype wire

// [verification/plc_host_model.sv]
// Host CPU model: one scan strobe per call, then reads the answer.
// Assumes the caller waits out reset before scanning.
`timescale 1ns/1ps
`default_nettype none
module plc_host_model (
    input wire logic clk_sys,
    input wire logic result_valid,
    input wire logic [31:0] result_word,
    output logic scan_pin
);
    initial scan_pin = 1'b0;
    // Strobe two cycles, wait bounded, keep two low cycles after
    task automatic scan(output logic [31:0] w, output logic ok);
        ok = 1'b0;
        w = '0;
        @(negedge clk_sys) scan_pin = 1'b1;
        repeat (2) @(negedge clk_sys);
        scan_pin = 1'b0;
        // Valid stands one cycle, so look at every falling edge
        for (int n = 0; n < 12 && !ok; n++)
        begin
            @(negedge clk_sys);
            if (result_valid === 1'b1)
            begin
                ok = 1'b1;
                w = result_word;
            end
        end
        repeat (2) @(negedge clk_sys);
    endtask
endmodule
`default_nettype wire

// [verification/ain_range_fmt_tb_top.sv]
// Self-checking bench for the range and units formatter.
// Assumes straps are set before each reset and sampled after it.
`timescale 1ns/1ps
`default_nettype none
module ain_range_fmt_tb_top;
    logic clk_sys = 1'b0; // 25 MHz clock
    logic arst_n = 1'b0; // Reset, low active
    logic wide_mode_pin = 1'b1; // Mode strap
    logic [2:0] range_pin = 3'h4; // Range strap
    logic [1:0] units_pin = 2'h0; // Units strap
    logic [1:0] chan_cnt_pin = 2'h3; // Last enabled channel
    logic [3:0] valid_cfg_pin = 4'h0; // Front end verdict
    logic [47:0] adc_codes = 48'h000fff123abc; // Four channel codes
    wire scan_pin; // From host model
    logic [31:0] result_word, w, e; // Answer, read value, expectation
    logic result_valid, run_led, ch1_led, cfg_bad, ok;
    logic [11:0] flash; // Lamp samples
    int n_mismatch = 0;
    int samples_checked = 0;
    always #20 clk_sys = ~clk_sys;
    ain_range_fmt #(.FLASH_CYC(4), .DEPTH(4)) u_dut (.clk_sys(clk_sys), .arst_n(arst_n),
        .wide_mode_pin(wide_mode_pin), .range_pin(range_pin), .units_pin(units_pin),
        .chan_cnt_pin(chan_cnt_pin), .valid_cfg_pin(valid_cfg_pin), .scan_pin(scan_pin),
        .adc_codes(adc_codes), .result_word(result_word), .result_valid(result_valid),
        .run_led(run_led), .ch1_led(ch1_led), .cfg_bad(cfg_bad));
    plc_host_model u_host (.clk_sys(clk_sys), .result_valid(result_valid),
        .result_word(result_word), .scan_pin(scan_pin));
    // Compare one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Straps count only at reset release, so each setup resets
    task automatic boot(input logic [11:0] s);
        @(negedge clk_sys);
        arst_n = 1'b0;
        {wide_mode_pin, range_pin, units_pin, chan_cnt_pin, valid_cfg_pin} = s;
        repeat (10) @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (6) @(negedge clk_sys);
    endtask
    // One scan that must be answered
    task automatic rd(input logic [31:0] mask, input logic [31:0] exp);
        u_host.scan(w, ok);
        chk({31'h0, ok}, 32'h1);
        chk(w & mask, exp);
    endtask
    // Verdict and end of run
    task automatic end_of_test();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        // Each units code, four channels rotating
        for (int u = 0; u < 4; u++)
        begin
            boot({4'hc, u[1:0], 6'h30});
            for (int k = 0; k < 5; k++)
            begin
                e = {12'h0, 4'h1 << (k % 4), 4'h0, adc_codes[12 * (k % 4) +: 12]};
                if (u == 2)
                    e[11:0] = {1'b0, e[11:1]};
                rd(32'hffff_ffff, e);
            end
        end
        // BCD ranges at full negative then zero, units ignored, two channels
        adc_codes = 48'h800800800000;
        for (int r = 0; r < 2; r++)
            for (int u = 0; u < 4; u++)
            begin
                boot({1'b1, r[2:0], u[1:0], 6'h10});
                rd(32'hffff_ffff, (r == 0) ? 32'h0011_9999 : 32'h0011_5000);
                rd(32'hffff_ffff, 32'h0002_0000);
            end
        // Narrow mode, units code set but ignored
        adc_codes = 48'h000fff123abc;
        boot({4'h4, 2'h2, 6'h10});
        for (int k = 0; k < 3; k++)
            rd(32'hffff_ffff, {18'h0, k[1:0] & 2'h1, adc_codes[12 * (k % 2) +: 12]});
        // Units moved after capture must not matter
        boot({4'hc, 2'h0, 6'h00});
        units_pin = 2'h2;
        rd(32'h0000_ffff, 32'h0000_0abc);
        // Loop current at and just above the threshold
        adc_codes = 48'h000000101100;
        boot({4'he, 2'h0, 6'h10});
        rd(32'h0f00_4000, 32'h0100_0000);
        rd(32'h0f00_4000, 32'h0000_0000);
        // Bad configuration: dark run lamp, flashing lamp, no answer
        boot({4'hc, 2'h0, 6'h31});
        chk({30'h0, run_led, cfg_bad}, 32'h1);
        for (int k = 0; k < 12; k++)
            @(negedge clk_sys) flash[k] = ch1_led;
        chk({31'h0, flash != 12'h000 && flash != 12'hfff}, 32'h1);
        u_host.scan(w, ok);
        chk({31'h0, ok}, 32'h0);
        end_of_test();
    end
    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (8000) @(posedge clk_sys);
        n_mismatch++;
        end_of_test();
    end
endmodule
`default_nettype wire
